/* ppiu_top.sv */
// Parallel interface unit: ports A, B and C with a control word.
// Assumes a host port with one-cycle strobes and pins synchronous to clk_i.
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "ppiu_consts.svh"

module ppiu_top
  import ppiu_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Host register port
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Port A pins
  input wire logic [7:0] pa_i,
  output var ppiu_pin_out_t pa_o,
  // Port B pins
  input wire logic [7:0] pb_i,
  output var ppiu_pin_out_t pb_o,
  // Port C pins
  input wire logic [7:0] pc_i,
  output var ppiu_pin_out_t pc_o
);

  // ****************************************************************
  // Host strobe decode
  // ****************************************************************

  logic ctrl_wr;
  logic mode_wr;
  logic bsr_wr;
  logic pa_wr;
  logic pb_wr;
  logic pc_wr;
  logic pa_rd;
  logic pb_rd;

  assign ctrl_wr = wr_i && (addr_i == `PPIU_ADDR_CTRL);
  assign mode_wr = ctrl_wr && wdata_i[`PPIU_CW_FLAG];
  assign bsr_wr = ctrl_wr && !wdata_i[`PPIU_CW_FLAG];
  assign pa_wr = wr_i && (addr_i == `PPIU_ADDR_PA);
  assign pb_wr = wr_i && (addr_i == `PPIU_ADDR_PB);
  assign pc_wr = wr_i && (addr_i == `PPIU_ADDR_PC);
  assign pa_rd = rd_i && (addr_i == `PPIU_ADDR_PA);
  assign pb_rd = rd_i && (addr_i == `PPIU_ADDR_PB);

  // ****************************************************************
  // Control word and its decode
  // ****************************************************************

  logic [7:0] cw_r;
  ppiu_cfg_t cfg;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cw_r <= `PPIU_CW_RESET;
    end
    else if (mode_wr)
    begin
      cw_r <= wdata_i;
    end
  end

  // Any mode 1x of group A is the bidirectional bus.
  always_comb
  begin
    cfg.mode_a = cw_r[`PPIU_CW_AM_HI] ? PPIU_BIDIR
                 : (cw_r[`PPIU_CW_AM_LO] ? PPIU_STROBED : PPIU_BASIC);
    cfg.a_in = cw_r[`PPIU_CW_A_IN];
    cfg.cu_in = cw_r[`PPIU_CW_CU_IN];
    cfg.b_strobed = cw_r[`PPIU_CW_BM];
    cfg.b_in = cw_r[`PPIU_CW_B_IN];
    cfg.cl_in = cw_r[`PPIU_CW_CL_IN];
  end

  // ****************************************************************
  // Strobed channels of group A and group B
  // ****************************************************************

  logic a_in_dir;
  logic a_out_dir;
  logic b_in_dir;
  logic b_out_dir;
  logic [7:0] a_in_data;
  logic [7:0] a_out_data;
  logic [7:0] b_in_data;
  logic [7:0] b_out_data;
  logic ibf_a;
  logic obf_n_a;
  logic ackd_a;
  logic ibf_b;
  logic obf_n_b;
  logic ackd_b;

  // In basic mode no direction enable is raised, so no handshake runs.
  assign a_in_dir = ((cfg.mode_a == PPIU_STROBED) && cfg.a_in)
                    || (cfg.mode_a == PPIU_BIDIR);
  assign a_out_dir = ((cfg.mode_a == PPIU_STROBED) && !cfg.a_in)
                     || (cfg.mode_a == PPIU_BIDIR);
  assign b_in_dir = cfg.b_strobed && cfg.b_in;
  assign b_out_dir = cfg.b_strobed && !cfg.b_in;

  ppiu_hs_chan u_chan_a (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .clear_i(mode_wr),
    .in_dir_i(a_in_dir),
    .out_dir_i(a_out_dir),
    .stb_n_i(pc_i[`PPIU_PC_STB_A]),
    .ack_n_i(pc_i[`PPIU_PC_ACK_A]),
    .pin_i(pa_i),
    .host_rd_i(pa_rd),
    .host_wr_i(pa_wr),
    .host_wdata_i(wdata_i),
    .in_data_o(a_in_data),
    .out_data_o(a_out_data),
    .ibf_o(ibf_a),
    .obf_n_o(obf_n_a),
    .ack_done_o(ackd_a)
  );

  ppiu_hs_chan u_chan_b (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .clear_i(mode_wr),
    .in_dir_i(b_in_dir),
    .out_dir_i(b_out_dir),
    .stb_n_i(pc_i[`PPIU_PC_STB_B]),
    .ack_n_i(pc_i[`PPIU_PC_STB_B]),
    .pin_i(pb_i),
    .host_rd_i(pb_rd),
    .host_wr_i(pb_wr),
    .host_wdata_i(wdata_i),
    .in_data_o(b_in_data),
    .out_data_o(b_out_data),
    .ibf_o(ibf_b),
    .obf_n_o(obf_n_b),
    .ack_done_o(ackd_b)
  );

  // ****************************************************************
  // Port C latch with single bit set and clear
  // ****************************************************************

  logic [7:0] pc_latch_r;
  logic [7:0] hs_mask;
  logic [2:0] bsr_sel;

  assign bsr_sel = wdata_i[`PPIU_BSR_SEL_HI:`PPIU_BSR_SEL_LO];

  // Plain port C writes leave the handshake-owned bits, the enables, alone.
  always_ff @(posedge clk_i)
  begin
    if (reset_i || mode_wr)
    begin
      pc_latch_r <= `PPIU_BYTE_ZERO;
    end
    else if (bsr_wr)
    begin
      pc_latch_r[bsr_sel] <= wdata_i[`PPIU_BSR_VAL];
    end
    else if (pc_wr)
    begin
      pc_latch_r <= (pc_latch_r & hs_mask) | (wdata_i & ~hs_mask);
    end
  end

  // ****************************************************************
  // Interrupt enables and requests
  // ****************************************************************

  logic inte_a_in;
  logic inte_a_out;
  logic inte_b;
  logic intr_a;
  logic intr_b;

  assign inte_a_in = pc_latch_r[`PPIU_PC_STB_A];
  assign inte_a_out = pc_latch_r[`PPIU_PC_ACK_A];
  assign inte_b = pc_latch_r[`PPIU_PC_STB_B];

  // Each enabled direction of group A raises the request; basic mode enables none.
  assign intr_a = (a_in_dir && inte_a_in && ibf_a)
                  || (a_out_dir && inte_a_out && ackd_a);

  assign intr_b = cfg.b_strobed && inte_b
                  && (cfg.b_in ? ibf_b : ackd_b);

  // ****************************************************************
  // Port C line ownership, drive and status
  // ****************************************************************

  logic [7:0] hs_val;
  logic [7:0] hs_oe;
  logic [7:0] hs_stat;

  always_comb
  begin
    hs_mask = `PPIU_BYTE_ZERO;
    hs_val = `PPIU_BYTE_ZERO;
    hs_oe = `PPIU_BYTE_ZERO;
    hs_stat = `PPIU_BYTE_ZERO;
    hs_val[`PPIU_PC_INTR_A] = intr_a;
    hs_stat[`PPIU_PC_INTR_A] = intr_a;
    hs_val[`PPIU_PC_IBF_A] = ibf_a;
    hs_stat[`PPIU_PC_IBF_A] = ibf_a;
    hs_val[`PPIU_PC_OBF_A] = obf_n_a;
    hs_stat[`PPIU_PC_OBF_A] = obf_n_a;
    hs_stat[`PPIU_PC_STB_A] = inte_a_in;
    hs_stat[`PPIU_PC_ACK_A] = inte_a_out;
    if (cfg.mode_a == PPIU_STROBED && cfg.a_in)
    begin
      // PC7 and PC6 stay general purpose lines here.
      hs_mask[`PPIU_PC_INTR_A] = 1'b1;
      hs_mask[`PPIU_PC_STB_A] = 1'b1;
      hs_mask[`PPIU_PC_IBF_A] = 1'b1;
    end
    else if (cfg.mode_a == PPIU_STROBED)
    begin
      hs_mask[`PPIU_PC_INTR_A] = 1'b1;
      hs_mask[`PPIU_PC_ACK_A] = 1'b1;
      hs_mask[`PPIU_PC_OBF_A] = 1'b1;
    end
    else if (cfg.mode_a == PPIU_BIDIR)
    begin
      hs_mask[`PPIU_NIB_UP] = 4'hf;
      hs_mask[`PPIU_PC_INTR_A] = 1'b1;
    end
    hs_oe[`PPIU_PC_INTR_A] = 1'b1;
    hs_oe[`PPIU_PC_IBF_A] = 1'b1;
    hs_oe[`PPIU_PC_OBF_A] = 1'b1;
    if (cfg.b_strobed)
    begin
      // Group B takes all three low lines it can use.
      hs_mask[`PPIU_PC_INTR_B] = 1'b1;
      hs_mask[`PPIU_PC_HS_B] = 1'b1;
      hs_mask[`PPIU_PC_STB_B] = 1'b1;
    end
    hs_val[`PPIU_PC_INTR_B] = intr_b;
    hs_val[`PPIU_PC_HS_B] = cfg.b_in ? ibf_b : obf_n_b;
    hs_oe[`PPIU_PC_INTR_B] = 1'b1;
    hs_oe[`PPIU_PC_HS_B] = 1'b1;
    hs_stat[`PPIU_PC_INTR_B] = intr_b;
    hs_stat[`PPIU_PC_HS_B] = hs_val[`PPIU_PC_HS_B];
    hs_stat[`PPIU_PC_STB_B] = inte_b;
  end

  // Direction of the port C lines left to general use.
  logic [7:0] gp_oe;

  assign gp_oe[`PPIU_NIB_UP] = cfg.cu_in ? 4'h0 : 4'hf;
  assign gp_oe[`PPIU_NIB_LO] = cfg.cl_in ? 4'h0 : 4'hf;

  // ****************************************************************
  // Pin drivers
  // ****************************************************************

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pc_o.data <= `PPIU_BYTE_ZERO;
      pc_o.oe <= `PPIU_BYTE_ZERO;
    end
    else
    begin
      pc_o.data <= (hs_mask & hs_val) | (~hs_mask & pc_latch_r);
      pc_o.oe <= (hs_mask & hs_oe) | (~hs_mask & gp_oe);
    end
  end

  // The bidirectional bus drives only while the peripheral acknowledges.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pa_o.data <= `PPIU_BYTE_ZERO;
      pa_o.oe <= `PPIU_BYTE_ZERO;
      pb_o.data <= `PPIU_BYTE_ZERO;
      pb_o.oe <= `PPIU_BYTE_ZERO;
    end
    else
    begin
      pa_o.data <= a_out_data;
      pb_o.data <= b_out_data;
      if (cfg.mode_a == PPIU_BIDIR)
      begin
        pa_o.oe <= pc_i[`PPIU_PC_ACK_A] ? `PPIU_BYTE_ZERO : `PPIU_BYTE_ONES;
      end
      else
      begin
        pa_o.oe <= cfg.a_in ? `PPIU_BYTE_ZERO : `PPIU_BYTE_ONES;
      end
      pb_o.oe <= cfg.b_in ? `PPIU_BYTE_ZERO : `PPIU_BYTE_ONES;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************

  logic [7:0] rd_mux;
  logic [7:0] pc_view;

  // Basic inputs read the live pins; strobed inputs read the latch.
  always_comb
  begin
    pc_view = (hs_mask & hs_stat)
              | (~hs_mask & gp_oe & pc_latch_r)
              | (~hs_mask & ~gp_oe & pc_i);
    rd_mux = `PPIU_BYTE_ZERO;
    unique case (addr_i)
      `PPIU_ADDR_PA:
      begin
        if (cfg.mode_a == PPIU_BASIC)
        begin
          rd_mux = cfg.a_in ? pa_i : a_out_data;
        end
        else if (cfg.mode_a == PPIU_BIDIR || cfg.a_in)
        begin
          rd_mux = a_in_data;
        end
        else
        begin
          rd_mux = a_out_data;
        end
      end
      `PPIU_ADDR_PB:
      begin
        if (!cfg.b_in)
        begin
          rd_mux = b_out_data;
        end
        else
        begin
          rd_mux = cfg.b_strobed ? b_in_data : pb_i;
        end
      end
      `PPIU_ADDR_PC:
      begin
        rd_mux = pc_view;
      end
      `PPIU_ADDR_CTRL:
      begin
        rd_mux = cw_r;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rdata_o <= `PPIU_BYTE_ZERO;
    end
    else
    begin
      rdata_o <= rd_i ? rd_mux : `PPIU_BYTE_ZERO;
    end
  end

endmodule : ppiu_top

`default_nettype wire

/* ppiu_consts.svh */
// Constants of the parallel interface unit: bus offsets, control word
// fields, port C handshake bit positions and reset values.
// Assumes inclusion by bare name from the package and the design modules.
//
// Behaviour
// - Three modes: basic, strobed, bidirectional bus.
// - One control word sets/clears one port C bit.
// - Bit set/clear drives handshake control bits.
// - Basic: A, B, two C nibbles, each direction.
// - Basic outputs latched, inputs read live pins.
// - Basic reads and writes need no handshake.
// - Bits 4,3,1,0 select input for A,CU,B,CL.
// - Strobed transfers handshake over port C lines.
// - Group A: A+upper C; group B: B+lower C.
// - Strobed ports latch data either direction.
// - Strobed groups request interrupts, each enableable.
// - Bidirectional only group A, five C lines.
// - Bidirectional latches both ways, interrupt enableable.
// - A strobed input leaves PC7, PC6 general.
// - B strobed takes PC0, PC1, PC2 only.
// - Port C read returns handshake and interrupt status.
// - PC5 high once port A input latched.
`ifndef PPIU_CONSTS_SVH
`define PPIU_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PPIU_ADDR_PA 2'h0
`define PPIU_ADDR_PB 2'h1
`define PPIU_ADDR_PC 2'h2
`define PPIU_ADDR_CTRL 2'h3

// ****************************************************************
// Control word fields
// ****************************************************************
`define PPIU_CW_FLAG 7
`define PPIU_CW_AM_HI 6
`define PPIU_CW_AM_LO 5
`define PPIU_CW_A_IN 4
`define PPIU_CW_CU_IN 3
`define PPIU_CW_BM 2
`define PPIU_CW_B_IN 1
`define PPIU_CW_CL_IN 0
`define PPIU_BSR_SEL_HI 3
`define PPIU_BSR_SEL_LO 1
`define PPIU_BSR_VAL 0
`define PPIU_CW_RESET 8'h9b

// ****************************************************************
// Port C handshake bit positions
// ****************************************************************
`define PPIU_PC_INTR_B 0
`define PPIU_PC_HS_B 1
`define PPIU_PC_STB_B 2
`define PPIU_PC_INTR_A 3
`define PPIU_PC_STB_A 4
`define PPIU_PC_IBF_A 5
`define PPIU_PC_ACK_A 6
`define PPIU_PC_OBF_A 7
`define PPIU_NIB_UP 7:4
`define PPIU_NIB_LO 3:0
`define PPIU_BYTE_ZERO 8'h00
`define PPIU_BYTE_ONES 8'hff

`endif

/* ppiu_pkg.sv */
// Types of the parallel interface unit.
// Assumes the constants header is on the include path.
`include "ppiu_consts.svh"

package ppiu_pkg;

  typedef enum logic [1:0] {PPIU_BASIC, PPIU_STROBED, PPIU_BIDIR} ppiu_mode_t;

  typedef struct packed {
    ppiu_mode_t mode_a;
    logic a_in;
    logic cu_in;
    logic b_strobed;
    logic b_in;
    logic cl_in;
  } ppiu_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] oe;
  } ppiu_pin_out_t;

endpackage : ppiu_pkg

/* ppiu_hs_chan.sv */
// One strobed data channel: input latch, output latch and buffer flags.
// Assumes pins synchronous to clk_i and strobes active low.
`timescale 1ns/100ps
`default_nettype none
`include "ppiu_consts.svh"

module ppiu_hs_chan
  import ppiu_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Configuration
  input wire logic clear_i,
  input wire logic in_dir_i,
  input wire logic out_dir_i,
  // Peripheral side
  input wire logic stb_n_i,
  input wire logic ack_n_i,
  input wire logic [7:0] pin_i,
  // Host side
  input wire logic host_rd_i,
  input wire logic host_wr_i,
  input wire logic [7:0] host_wdata_i,
  output logic [7:0] in_data_o,
  output logic [7:0] out_data_o,
  output logic ibf_o,
  output logic obf_n_o,
  output logic ack_done_o
);

  logic stb_prev_r;
  logic ack_prev_r;
  logic stb_fall;
  logic ack_fall;

  assign stb_fall = stb_prev_r & ~stb_n_i;
  assign ack_fall = ack_prev_r & ~ack_n_i;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      stb_prev_r <= 1'b1;
      ack_prev_r <= 1'b1;
    end
    else
    begin
      stb_prev_r <= stb_n_i;
      ack_prev_r <= ack_n_i;
    end
  end

  // Both latches hold their data whatever the direction.
  always_ff @(posedge clk_i)
  begin
    if (reset_i || clear_i)
    begin
      in_data_o <= `PPIU_BYTE_ZERO;
      out_data_o <= `PPIU_BYTE_ZERO;
    end
    else
    begin
      if (in_dir_i && stb_fall)
      begin
        in_data_o <= pin_i;
      end
      if (host_wr_i)
      begin
        out_data_o <= host_wdata_i;
      end
    end
  end

  // A strobe in the cycle of the host read keeps the buffer full.
  always_ff @(posedge clk_i)
  begin
    if (reset_i || clear_i)
    begin
      ibf_o <= 1'b0;
    end
    else if (in_dir_i && stb_fall)
    begin
      ibf_o <= 1'b1;
    end
    else if (host_rd_i)
    begin
      ibf_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i || clear_i)
    begin
      obf_n_o <= 1'b1;
      ack_done_o <= 1'b0;
    end
    else
    begin
      if (out_dir_i && host_wr_i)
      begin
        obf_n_o <= 1'b0;
      end
      else if (ack_fall)
      begin
        obf_n_o <= 1'b1;
      end
      if (out_dir_i && ack_fall)
      begin
        ack_done_o <= 1'b1;
      end
      else if (host_wr_i)
      begin
        ack_done_o <= 1'b0;
      end
    end
  end

endmodule : ppiu_hs_chan

`default_nettype wire

/* ppiu_props.sv */
// Checker of the parallel interface unit, watching only the top ports.
// Assumes the bind at the foot of this file and one clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "ppiu_consts.svh"

module ppiu_props
  import ppiu_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Host port
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // Pins
  input wire logic [7:0] pa_i,
  input wire ppiu_pin_out_t pa_o,
  input wire logic [7:0] pb_i,
  input wire ppiu_pin_out_t pb_o,
  input wire logic [7:0] pc_i,
  input wire ppiu_pin_out_t pc_o
);
  // ****
  // Shadow of the control word
  // ****
  logic [7:0] cw_r;
  logic inte_r;
  logic cw_wr;
  logic bit_wr;
  logic basic;
  logic a_sin;
  assign cw_wr = wr_i && addr_i == 2'h3 && wdata_i[7];
  assign bit_wr = wr_i && addr_i == 2'h3 && !wdata_i[7];
  assign basic = cw_r[6:5] == 2'h0 && !cw_r[2];
  assign a_sin = cw_r[6:5] == 2'h1 && cw_r[4];

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      cw_r <= `PPIU_CW_RESET;
    else if (cw_wr)
      cw_r <= wdata_i;
  end

  // The enable of group A input follows set and clear of port C bit 4.
  always_ff @(posedge clk_i)
  begin
    if (reset_i || cw_wr)
      inte_r <= 1'b0;
    else if (bit_wr && wdata_i[3:1] == 3'h4)
      inte_r <= wdata_i[0];
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  // ****
  // Properties
  // ****
  property p_rd_idle;
    !$past(rd_i) |-> rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside a read");
  property p_cw_read;
    rd_i && addr_i == 2'h3 |=> rdata_o == $past(cw_r);
  endproperty
  a_cw_read: assert property (p_cw_read)
    else $error("control word read back wrong");
  property p_live_in;
    rd_i && addr_i == 2'h0 && cw_r[6:5] == 2'h0 && cw_r[4] |=> rdata_o == $past(pa_i);
  endproperty
  a_live_in: assert property (p_live_in)
    else $error("basic input read not live");
  property p_dir;
    basic && $stable(cw_r) |-> pa_o.oe == {8{!cw_r[4]}} && pb_o.oe == {8{!cw_r[1]}}
      && pc_o.oe == {{4{!cw_r[3]}}, {4{!cw_r[0]}}};
  endproperty
  a_dir: assert property (p_dir)
    else $error("basic port direction wrong");
  property p_out_latch;
    (wr_i && addr_i == 2'h0 && cw_r[6:5] == 2'h0 && !cw_r[4]) ##1 !wr_i
      |=> pa_o.data == $past(wdata_i, 2);
  endproperty
  a_out_latch: assert property (p_out_latch)
    else $error("port A output latch wrong");
  property p_bit_cmd;
    (bit_wr && basic && !cw_r[3] && !cw_r[0]) ##1 !wr_i
      |=> pc_o.data[$past(wdata_i[3:1], 2)] == $past(wdata_i[0], 2)
      && ((pc_o.data ^ $past(pc_o.data)) & ~(8'h01 << $past(wdata_i[3:1], 2))) == 8'h00;
  endproperty
  a_bit_cmd: assert property (p_bit_cmd)
    else $error("port C bit command wrong");
  property p_ibf_a;
    a_sin && $fell(pc_i[4]) |-> ##[1:3] pc_o.data[5];
  endproperty
  a_ibf_a: assert property (p_ibf_a)
    else $error("group A buffer full missing");
  property p_intr_a;
    a_sin && $stable(cw_r) && $stable(inte_r) |-> pc_o.data[3] == (inte_r && pc_o.data[5]);
  endproperty
  a_intr_a: assert property (p_intr_a)
    else $error("group A request wrong");
  property p_bidir;
    cw_r[6] && $stable(cw_r) |-> pa_o.oe == ($past(pc_i[6]) ? 8'h00 : 8'hff);
  endproperty
  a_bidir: assert property (p_bidir)
    else $error("bidirectional enable wrong");

  c_mode: cover property (cw_wr && wdata_i[6]);
  c_ibf: cover property (a_sin && $rose(pc_o.data[5]));
  c_bit: cover property (bit_wr);
endmodule : ppiu_props

bind ppiu_top ppiu_props i_ppiu_props (.clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .pa_i, .pa_o, .pb_i, .pb_o, .pc_i, .pc_o);
`default_nettype wire

/* ppiu_periph.sv */
// Peripheral model at the port pins: levels, strobes and acknowledges.
// Assumes strobe lines idle high and the bench calling its tasks.
`timescale 1ns/100ps
`default_nettype none

module ppiu_periph
  import ppiu_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Device pins
  input wire ppiu_pin_out_t pa_o,
  input wire ppiu_pin_out_t pb_o,
  input wire ppiu_pin_out_t pc_o,
  output logic [7:0] pa_i,
  output logic [7:0] pb_i,
  output logic [7:0] pc_i
);
  // ****
  // Wire levels
  // ****
  logic [7:0] a_r = 8'h00;
  logic [7:0] b_r = 8'h00;
  logic [7:0] c_r = 8'hff;
  assign pa_i = (pa_o.oe & pa_o.data) | (~pa_o.oe & a_r);
  assign pb_i = (pb_o.oe & pb_o.data) | (~pb_o.oe & b_r);
  assign pc_i = (pc_o.oe & pc_o.data) | (~pc_o.oe & c_r);

  task automatic set_pins(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    @(posedge clk_i);
    a_r <= a;
    b_r <= b;
    c_r <= c;
  endtask : set_pins

  // Strobe held low two cycles; data then kept for gap cycles and turned round.
  task automatic strobe(input logic grp_a, input logic [7:0] d, input int gap);
    @(posedge clk_i);
    if (grp_a)
      a_r <= d;
    else
      b_r <= d;
    c_r <= c_r & (grp_a ? 8'hef : 8'hfb);
    repeat (2) @(posedge clk_i);
    c_r <= c_r | (grp_a ? 8'h10 : 8'h04);
    repeat (gap) @(posedge clk_i);
    if (grp_a)
      a_r <= ~d;
    else
      b_r <= ~d;
  endtask : strobe
endmodule : ppiu_periph
`default_nettype wire

/* ppiu_tb.sv */
// Testbench of the parallel interface unit over its host port.
// Assumes the peripheral model and the bound checker beside it.
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import ppiu_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [1:0] addr_i = 2'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic [7:0] pa_i, pb_i, pc_i;
  ppiu_pin_out_t pa_o, pb_o, pc_o;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [7:0] got;
  logic [7:0] exp;
  logic [7:0] cfg [6] = '{8'h80, 8'h90, 8'h88, 8'h82, 8'h81, 8'h9b};

  always #5 clk_i = ~clk_i;

  ppiu_top i_ppiu_top (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pa_i(pa_i), .pa_o(pa_o), .pb_i(pb_i),
    .pb_o(pb_o), .pc_i(pc_i), .pc_o(pc_o));
  ppiu_periph i_ppiu_periph (.clk_i(clk_i), .pa_o(pa_o), .pb_o(pb_o), .pc_o(pc_o),
    .pa_i(pa_i), .pb_i(pb_i), .pc_i(pc_i));

  // ****
  // Host port tasks
  // ****
  task automatic check(input string name, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", name, e, g);
      errors++;
    end
  endtask : check
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd
  task automatic settle();
    repeat (2) @(posedge clk_i);
    #1;
  endtask : settle
  task automatic poll(input int bit_n);
    for (int n = 0; n < 10; n++)
    begin
      rd(2'h2, got);
      if (got[bit_n])
        break;
    end
  endtask : poll
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      wrap_up();
    end
  end

  // ****
  // Tests
  // ****
  initial
  begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(2'h3, got);
    check("reset control word", 8'h9b, got);
    check("reset port A enables", 8'h00, pa_o.oe);
    $display("test reset done");
    foreach (cfg[k])
    begin
      wr(2'h3, cfg[k]);
      settle();
      check("port A enables", {8{~cfg[k][4]}}, pa_o.oe);
      check("port B enables", {8{~cfg[k][1]}}, pb_o.oe);
      check("port C enables", {{4{~cfg[k][3]}}, {4{~cfg[k][0]}}}, pc_o.oe);
      rd(2'h3, got);
      check("control readback", cfg[k], got);
    end
    $display("test directions done");
    wr(2'h3, 8'h80);
    wr(2'h0, 8'h5a);
    wr(2'h1, 8'hc3);
    wr(2'h2, 8'h3c);
    settle();
    check("port A pins", 8'h5a, pa_o.data);
    check("port B pins", 8'hc3, pb_o.data);
    check("port C pins", 8'h3c, pc_o.data);
    rd(2'h0, got);
    check("port A latch", 8'h5a, got);
    wr(2'h3, 8'h90);
    i_ppiu_periph.set_pins(8'ha5, 8'h00, 8'hff);
    rd(2'h0, got);
    check("port A live", 8'ha5, got);
    i_ppiu_periph.set_pins(8'h42, 8'h00, 8'hff);
    rd(2'h0, got);
    check("port A live again", 8'h42, got);
    $display("test basic done");
    wr(2'h3, 8'h80);
    exp = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      wr(2'h3, {4'h0, i[2:0], 1'b1});
      exp = exp | (8'h01 << i);
      settle();
      check("port C bit set", exp, pc_o.data);
    end
    wr(2'h3, 8'h06);
    settle();
    check("port C bit clear", 8'hf7, pc_o.data);
    $display("test bit commands done");
    wr(2'h3, 8'hb0);
    wr(2'h3, 8'h09);
    wr(2'h3, 8'h0f);
    i_ppiu_periph.strobe(1'b1, 8'h6d, 3);
    poll(5);
    check("group A input status", 8'hb8, got);
    rd(2'h0, got);
    check("port A input latch", 8'h6d, got);
    rd(2'h2, got);
    check("group A status cleared", 8'h10, got & 8'h38);
    wr(2'h3, 8'h08);
    i_ppiu_periph.strobe(1'b1, 8'h24, 0);
    poll(5);
    check("group A request masked", 8'h20, got & 8'h38);
    rd(2'h0, got);
    check("port A second latch", 8'h24, got);
    wr(2'h3, 8'ha0);
    wr(2'h3, 8'h0d);
    wr(2'h0, 8'h77);
    rd(2'h2, got);
    check("group A output status", 8'h40, got);
    check("strobed A output", 8'h77, pa_o.data);
    i_ppiu_periph.set_pins(8'h00, 8'h00, 8'hbf);
    i_ppiu_periph.set_pins(8'h00, 8'h00, 8'hff);
    rd(2'h2, got);
    check("group A acknowledged", 8'hc8, got);
    $display("test strobed A done");
    wr(2'h3, 8'h86);
    wr(2'h3, 8'h05);
    i_ppiu_periph.strobe(1'b0, 8'hc9, 1);
    poll(1);
    check("group B input status", 8'h07, got & 8'h07);
    rd(2'h1, got);
    check("port B input latch", 8'hc9, got);
    $display("test strobed B done");
    wr(2'h3, 8'hc0);
    wr(2'h0, 8'h99);
    settle();
    check("bus idle enables", 8'h00, pa_o.oe);
    i_ppiu_periph.set_pins(8'h00, 8'h00, 8'hbf);
    settle();
    check("bus drive enables", 8'hff, pa_o.oe);
    check("bus drive data", 8'h99, pa_o.data);
    i_ppiu_periph.set_pins(8'h00, 8'h00, 8'hff);
    i_ppiu_periph.strobe(1'b1, 8'h3c, 1);
    poll(5);
    rd(2'h0, got);
    check("bus input latch", 8'h3c, got);
    $display("test bidirectional done");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
